/* File: src/osc_params.svh */
// Constants of the octal switch serial control block.
// Assumes one 200 MHz system clock; included by bare name.
`ifndef OSC_PARAMS_SVH
`define OSC_PARAMS_SVH

// Channel count and serial word width
`define OSC_NCH 8
// Bit counter width, a word is eight clocks
`define OSC_CNT_W 3
`define OSC_CNT_LAST 3'h7
`define OSC_CNT_ZERO 3'h0
// Latch value after reset or kill, all off
`define OSC_LATCH_RST 8'h00
// System clock rate
`define OSC_CLK_MHZ 200
// Least settling time of the input side
`define OSC_SETTLE_NS 1000
// Settling time in cycles, rounded up
`define OSC_SETTLE_CYC ((`OSC_SETTLE_NS * `OSC_CLK_MHZ + 999) / 1000)
`define OSC_SETTLE_W 8

`endif

/* File: src/osc_pkg.sv */
// Types shared by the octal switch serial control block.
// Assumes osc_params.svh is on the include path.
`include "osc_params.svh"

package osc_pkg;

   // Capture controller state
   typedef enum logic {
      CTL_IDLE,
      CTL_FRAME
   } osc_ctl_e;

   // Word and bit count handed from the serial clock side
   typedef struct packed {
      logic [`OSC_NCH-1:0] word;
      logic [`OSC_CNT_W-1:0] cnt;
      logic got;
   } osc_link_s;

   // Serial clock side counter state
   typedef struct packed {
      logic [`OSC_CNT_W-1:0] cnt;
      logic got;
   } osc_cnt_s;

   // System clock side state
   typedef struct packed {
      logic [1:0] cs_sync;
      logic [`OSC_NCH-1:0] ot1;
      logic [`OSC_NCH-1:0] ot2;
      logic [1:0] uv_sync;
      logic [1:0] rdy_sync;
      logic [`OSC_SETTLE_W-1:0] settle;
      logic ready;
      osc_ctl_e ctl;
      logic clr;
      logic [`OSC_NCH-1:0] latch;
      logic [`OSC_NCH-1:0] chan;
      logic fault_oe;
   } osc_top_s;

endpackage : osc_pkg

/* File: src/osc_link_shift.sv */
// Serial clock side of the octal switch control: shift register,
// modulo bit counter and the daisy chain output.
// Assumes the master holds sclk high across chip select edges.
`timescale 1ns/1ps
`default_nettype none
`include "osc_params.svh"

module osc_link_shift (
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic si,
   input wire logic kill_n,
   input wire logic cnt_clr,
   output osc_pkg::osc_link_s link,
   output logic so,
   output logic so_oe
);

   // Input shift register, cleared by the kill pin
   logic [`OSC_NCH-1:0] shreg;
   // Clock counter of the current frame
   osc_pkg::osc_cnt_s cst;
   osc_pkg::osc_cnt_s next_cst;
   // Counter clear: end of frame taken, or kill
   logic cnt_rst;

   assign cnt_rst = cnt_clr | ~kill_n;

   // Shift in, MSB first, only while selected
   always_ff @(posedge sclk or negedge kill_n) begin
      if (!kill_n) begin
         shreg <= `OSC_LATCH_RST; // see RQ9
      end else if (!cs_n) begin
         shreg <= {shreg[`OSC_NCH-2:0], si}; // see RQ3 see RQ15 see RQ18
      end
   end

   // Count clocks; got marks at least one full word
   always_comb begin
      next_cst = cst;
      if (!cs_n) begin
         next_cst.cnt = `OSC_CNT_W'(cst.cnt + 1'b1); // see RQ16
         if (cst.cnt == `OSC_CNT_LAST) begin
            next_cst.got = 1'b1;
         end
      end
   end

   // Cleared from the system side once the frame is taken
   always_ff @(posedge sclk or posedge cnt_rst) begin
      if (cnt_rst) begin
         cst <= '0;
      end else begin
         cst <= next_cst;
      end
   end

   // Output bit follows the falling edge, MSB leaves first
   always_ff @(negedge sclk or negedge kill_n) begin
      if (!kill_n) begin
         so <= 1'b0;
      end else if (!cs_n) begin
         so <= shreg[`OSC_NCH-1]; // see RQ4 see RQ14
      end
   end

   // Drive only inside a frame; chip select high floats it at once
   always_ff @(negedge sclk or posedge cs_n) begin
      if (cs_n) begin
         so_oe <= 1'b0; // see RQ5
      end else begin
         so_oe <= 1'b1;
      end
   end

   assign link = '{word: shreg, cnt: cst.cnt, got: cst.got};

   // Each rising edge moves the word one place and takes si
   a_shift_in: assert property (@(posedge sclk) disable iff (!kill_n) // see RQ3
      !cs_n ##1 !cs_n |-> shreg == {$past(shreg[`OSC_NCH-2:0]), $past(si)})
      else $error("shift register did not take si");

   // The bit driven out is the top bit seen at the falling edge
   a_so_msb: assert property (@(negedge sclk) disable iff (!kill_n) // see RQ14
      !cs_n ##1 !cs_n |-> so == $past(shreg[`OSC_NCH-1]))
      else $error("serial output is not the shift register top bit");

endmodule : osc_link_shift
`default_nettype wire

/* File: src/osc_serial_ctrl.sv */
// Top of the octal load switch serial control block: chip select
// capture, output latches, kill, settling and fault flag.
// Assumes pins arrive unsynchronised; sclk is a clock of its own.
//
// Notes on behaviour
// RQ1 - Eight-bit word, one latch per channel
// RQ2 - Latched one turns channel on
// RQ3 - Sample si on sclk rise when selected
// RQ4 - Serial output changes after falling edge
// RQ5 - Serial output floats while chip select high
// RQ6 - Master keeps select low for whole word
// RQ7 - Select rising edge loads latches
// RQ8 - Kill pin turns all channels off
// RQ9 - Kill also clears shift register, latches
// RQ10 - After kill, off until new word
// RQ11 - Fault flag ORs eight overtemperature detectors
// RQ12 - Fault flag also low on undervoltage
// RQ13 - Outputs off until input side settled
// RQ14 - Serial output carries shift register bits
// RQ15 - Words travel most significant bit first
// RQ16 - Load only on whole multiple of eight
// RQ17 - Master holds sclk high at select edges
// RQ18 - Ignore sclk and si when deselected
// RQ19 - Word bit n drives channel n
`timescale 1ns/1ps
`default_nettype none
`include "osc_params.svh"

module osc_serial_ctrl (
   input wire logic clk,
   input wire logic rst_n,
   // Serial link, clocked by the master
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic si,
   output logic so_o,
   output logic so_oe,
   // Low active kill of all channels
   input wire logic output_kill_n,
   // Per channel overtemperature, high when hot
   input wire logic [`OSC_NCH-1:0] over_temp,
   // Driver supply below switch-on limit
   input wire logic vbb_under,
   // Input interface supply is up
   input wire logic iface_ready,
   // Open drain fault flag, low active
   output logic fault_flag_n_o,
   output logic fault_flag_n_oe,
   // Channel drive, one bit per switch
   output logic [`OSC_NCH-1:0] load_switch_channels
);

   // Settling target, in system clock cycles
   localparam logic [`OSC_SETTLE_W-1:0] SETTLE_T =
      `OSC_SETTLE_W'(`OSC_SETTLE_CYC);

   // State after reset: idle, select seen high,
   // counter held clear, everything off
   localparam osc_pkg::osc_top_s ST_RST = '{
      cs_sync: 2'h3,
      ot1: `OSC_LATCH_RST,
      ot2: `OSC_LATCH_RST,
      uv_sync: 2'h0,
      rdy_sync: 2'h0,
      settle: '0,
      ready: 1'b0,
      ctl: osc_pkg::CTL_IDLE,
      clr: 1'b1,
      latch: `OSC_LATCH_RST,
      chan: `OSC_LATCH_RST,
      fault_oe: 1'b0
   };

   // Registered state and its next value
   osc_pkg::osc_top_s st;
   osc_pkg::osc_top_s next_st;

   // Word and count from the serial clock side
   osc_pkg::osc_link_s link;

   // Reset source: system reset or kill pin
   logic kill_any_n;
   // Reset synchroniser, asserts at once, releases on clk
   logic [1:0] rst_sync;
   // System reset, kill folded in
   logic srst_n;

   // Frame end seen on synchronised select
   logic take;
   // Count is a whole number of words, at least one
   logic word_ok;

   // Serial clock side: shift, count, daisy chain output
   osc_link_shift u_link (
      .sclk(sclk),
      .cs_n(cs_n),
      .si(si),
      .kill_n(output_kill_n),
      .cnt_clr(st.clr),
      .link(link),
      .so(so_o),
      .so_oe(so_oe)
   );

   // Either reset source clears the control state
   assign kill_any_n = rst_n & output_kill_n;

   // Kill acts without the clock; only the release is
   // synchronised, so latches never glitch on recovery
   always_ff @(posedge clk or negedge kill_any_n) begin
      if (!kill_any_n) begin
         rst_sync <= 2'h0; // see RQ8
      end else begin
         rst_sync <= {rst_sync[0], 1'b1};
      end
   end

   assign srst_n = rst_sync[1];

   // The frame ends when synchronised select is high
   // while the controller still sits in a frame
   assign take = (st.ctl == osc_pkg::CTL_FRAME) && st.cs_sync[1];

   // Zero clocks or a broken word is discarded
   assign word_ok = link.got && (link.cnt == `OSC_CNT_ZERO); // see RQ16

   // Next state of the system clock side
   always_comb begin
      next_st = st;

      // Two flip-flops on every pin before use
      next_st.cs_sync = {st.cs_sync[0], cs_n};
      next_st.ot1 = over_temp;
      next_st.ot2 = st.ot1;
      next_st.uv_sync = {st.uv_sync[0], vbb_under};
      next_st.rdy_sync = {st.rdy_sync[0], iface_ready};

      // Settle: the input side must stay up for the
      // whole time before channels may follow latches
      if (!st.rdy_sync[1]) begin
         next_st.settle = '0; // see RQ13
      end else if (st.settle != SETTLE_T) begin
         next_st.settle = `OSC_SETTLE_W'(st.settle + 1'b1);
      end
      next_st.ready = (next_st.settle == SETTLE_T); // see RQ13

      // Capture controller
      unique case (st.ctl)
         // Wait for select to fall; counter held clear
         osc_pkg::CTL_IDLE: begin
            if (!st.cs_sync[1]) begin
               next_st.ctl = osc_pkg::CTL_FRAME;
            end
         end
         // In a frame: the word is taken when select rises.
         // The link side is quiet by then, because sclk
         // stands high and is ignored once select is high.
         osc_pkg::CTL_FRAME: begin
            if (st.cs_sync[1]) begin
               next_st.ctl = osc_pkg::CTL_IDLE; // see RQ6 see RQ17
               if (word_ok) begin
                  // Bit n of the word drives channel n
                  next_st.latch = link.word; // see RQ7 see RQ19 see RQ1
               end
            end
         end
      endcase

      // Clear the link counter outside frames
      next_st.clr = (next_st.ctl == osc_pkg::CTL_IDLE);

      // A one turns a channel on, gated by settling
      next_st.chan = next_st.ready ? next_st.latch : `OSC_LATCH_RST; // see RQ2

      // Any hot channel or low driver supply pulls the flag
      next_st.fault_oe = (|st.ot2) | st.uv_sync[1]; // see RQ11 see RQ12
   end

   // System side state but the reset synchroniser in one register; kill clears
   // latches, so channels stay off until a new word
   always_ff @(posedge clk or negedge srst_n) begin
      if (!srst_n) begin
         st <= ST_RST; // see RQ9 see RQ10
      end else begin
         st <= next_st;
      end
   end

   // Outputs straight from flip-flops
   assign load_switch_channels = st.chan;
   assign fault_flag_n_oe = st.fault_oe;
   // Open drain: only ever pulls low
   assign fault_flag_n_o = 1'b0;

   // Checks on the system clock
   default clocking dc @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   // Channels are off whenever kill is held
   a_kill_off: assert property ( // see RQ8
      !output_kill_n |-> load_switch_channels == `OSC_LATCH_RST)
      else $error("channel on while kill is held");

   // The latches themselves are cleared during kill
   a_kill_latch: assert property ( // see RQ9
      !output_kill_n |-> st.latch == `OSC_LATCH_RST)
      else $error("latch not cleared during kill");

   // A good frame end loads the shifted word
   a_load_good: assert property ( // see RQ7
      take && word_ok && srst_n |=> st.latch == $past(link.word))
      else $error("good word not loaded at frame end");

   // A frame with a broken count leaves latches alone
   a_load_bad: assert property ( // see RQ16
      take && !word_ok && srst_n && output_kill_n |=> $stable(st.latch))
      else $error("broken word was loaded");

   // Nothing changes the latches between frames
   a_idle_hold: assert property (
      @(posedge clk) disable iff (!srst_n || !output_kill_n) // see RQ18
      st.ctl == osc_pkg::CTL_IDLE |=> $stable(st.latch))
      else $error("latch changed outside a frame end");

   // Settled channels mirror the latches bit for bit
   a_chan_map: assert property ( // see RQ19
      st.ready |-> load_switch_channels == st.latch)
      else $error("channel does not follow its latch");

   // Unsettled input side keeps every channel off
   a_settle_off: assert property ( // see RQ13
      !st.ready |-> load_switch_channels == `OSC_LATCH_RST)
      else $error("channel on before input side settled");

   // Four cycles of any fault cause pull the flag
   a_fault_set: assert property ( // see RQ11
      ((|over_temp || vbb_under) && srst_n) [*4] |-> fault_flag_n_oe)
      else $error("fault flag not pulled on fault");

   // Four quiet cycles release the flag
   a_fault_clr: assert property ( // see RQ12
      (!(|over_temp || vbb_under) && srst_n) [*4] |-> !fault_flag_n_oe)
      else $error("fault flag held without a cause");

   // The serial output never drives while deselected
   a_so_float: assert property ( // see RQ5
      cs_n |-> !so_oe)
      else $error("serial output driven while deselected");

endmodule : osc_serial_ctrl
`default_nettype wire

/* File: tb/osc_master_model.sv */
// Serial bus master model that drives frames into the switch control.
// Assumes the device samples si on sclk rise and shifts so on fall.
`timescale 1ns/1ps
`default_nettype none

module osc_master_model (
   output logic sclk,
   output logic cs_n,
   output logic si,
   input wire logic so_o,
   input wire logic so_oe
);
   localparam int HALF = 40; // Half of the 80 ns link period
   logic [15:0] rx; // Bits seen on so during the last frame
   int oe_bad; // Rises at which so was not driven

   // Idle bus: clock parked high, deselected
   initial begin
      sclk = 1'b1;
      cs_n = 1'b1;
      si = 1'b0;
      rx = 16'h0000;
      oe_bad = 0;
   end

   // One frame of n clocks, msb first; odd offset keeps phase unrelated
   task automatic frame(input logic [15:0] data, input int n);
      #3;
      cs_n = 1'b0;
      #(HALF);
      for (int i = n - 1; i >= 0; i--) begin
         sclk = 1'b0;
         si = data[i];
         #(HALF);
         sclk = 1'b1;
         rx = {rx[14:0], so_o};
         if (so_oe !== 1'b1) oe_bad++;
         #(HALF);
      end
      cs_n = 1'b1;
      si = ~si; // Released line must not hold the last bit
      #(HALF * 2);
   endtask : frame

   // Clock and data noise while deselected, clock ends high
   task automatic noise(input int n);
      for (int i = 0; i < n; i++) begin
         sclk = 1'b0;
         si = ~si;
         #(HALF);
         sclk = 1'b1;
         #(HALF);
      end
   endtask : noise
endmodule : osc_master_model
`default_nettype wire

/* File: tb/test_isolated_octal_switch_serial_ctrl.sv */
// Self-checking bench of the octal switch serial control.
// Assumes the master model drives the link; bench drives the rest.
`timescale 1ns/1ps
`default_nettype none
`include "osc_params.svh"

module test_isolated_octal_switch_serial_ctrl;
   typedef struct packed {
      logic [15:0] data;
      logic [4:0] n;
      logic [7:0] exp;
   } osc_row_s;
   logic clk = 1'b0;
   logic rst_n, output_kill_n, vbb_under, iface_ready;
   logic [`OSC_NCH-1:0] over_temp, load_switch_channels;
   logic sclk, cs_n, si, so_o, so_oe, fault_flag_n_o, fault_flag_n_oe;
   wire fault_flag_n = fault_flag_n_oe ? fault_flag_n_o : 1'b1; // Pull-up
   int mismatches = 0;
   int tests_run = 0;
   logic [7:0] sh; // Expected shift register
   logic [15:0] erx, msk; // Expected so bits and their mask
   // Rows: frame data, clock count, channels after; bad counts keep old
   osc_row_s rows [8] = '{'{16'h00A5, 5'd8, 8'hA5}, '{16'h0001, 5'd8, 8'h01},
      '{16'h0080, 5'd8, 8'h80}, '{16'hC33C, 5'd16, 8'h3C}, '{16'h007F, 5'd7, 8'h3C},
      '{16'h00FF, 5'd8, 8'hFF}, '{16'h0000, 5'd0, 8'hFF}, '{16'h0000, 5'd8, 8'h00}};

   always #2.5 clk = ~clk;

   osc_serial_ctrl u_dut (.clk(clk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .si(si),
      .so_o(so_o), .so_oe(so_oe), .output_kill_n(output_kill_n), .over_temp(over_temp),
      .vbb_under(vbb_under), .iface_ready(iface_ready), .fault_flag_n_o(fault_flag_n_o),
      .fault_flag_n_oe(fault_flag_n_oe), .load_switch_channels(load_switch_channels));
   osc_master_model u_mst (.sclk(sclk), .cs_n(cs_n), .si(si), .so_o(so_o), .so_oe(so_oe));

   // Compare and count
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // Bounded wait for the channels, then compare
   task automatic wait_ch(input logic [7:0] exp);
      for (int i = 0; i < 40 && load_switch_channels !== exp; i++) @(negedge clk);
      chk(load_switch_channels, exp);
   endtask : wait_ch

   // Bounded wait for the fault pin level, then compare
   task automatic wait_ff(input logic exp);
      for (int i = 0; i < 20 && fault_flag_n !== exp; i++) @(negedge clk);
      chk(fault_flag_n, exp);
   endtask : wait_ff

   // Verdict and end of run
   task automatic end_sim;
      $display("checks %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : end_sim

   // Main sequence
   initial begin
      rst_n = 1'b0;
      output_kill_n = 1'b0;
      vbb_under = 1'b0;
      iface_ready = 1'b1;
      over_temp = '0;
      repeat (3) @(negedge clk);
      chk(load_switch_channels, 8'h00);
      chk(fault_flag_n, 1'b1);
      rst_n = 1'b1;
      output_kill_n = 1'b1;
      sh = 8'h00; // Kill cleared the shift register
      repeat (220) @(negedge clk);
      // Table of frames
      for (int r = 0; r < 8; r++) begin
         erx = 16'h0000;
         for (int i = rows[r].n - 1; i >= 0; i--) begin
            erx = {erx[14:0], sh[7]};
            sh = {sh[6:0], rows[r].data[i]};
         end
         msk = (rows[r].n == 0) ? 16'h0000 : 16'hFFFF >> (16 - rows[r].n);
         u_mst.frame(rows[r].data, int'(rows[r].n));
         @(negedge clk);
         chk(u_mst.rx & msk, erx & msk);
         wait_ch(rows[r].exp);
         chk(so_oe, 1'b0);
         $display("row %0d done", r);
      end
      chk(16'(u_mst.oe_bad), 16'h0000);
      // Kill mid-run, stays off, noise ignored
      u_mst.frame(16'h005A, 8);
      wait_ch(8'h5A);
      output_kill_n = 1'b0;
      #1;
      chk(load_switch_channels, 8'h00);
      @(negedge clk);
      output_kill_n = 1'b1;
      repeat (220) @(negedge clk);
      chk(load_switch_channels, 8'h00);
      u_mst.noise(5);
      repeat (20) @(negedge clk);
      chk(load_switch_channels, 8'h00);
      u_mst.frame(16'h0081, 8);
      @(negedge clk);
      chk(u_mst.rx[7:0], 8'h00);
      wait_ch(8'h81);
      $display("kill test done");
      // Each overtemperature detector and the supply monitor
      for (int b = 0; b < 8; b++) begin
         over_temp = 8'h01 << b;
         wait_ff(1'b0);
         over_temp = '0;
         wait_ff(1'b1);
      end
      vbb_under = 1'b1;
      wait_ff(1'b0);
      vbb_under = 1'b0;
      wait_ff(1'b1);
      $display("fault test done");
      // Input side drop: off, then back only after settling
      iface_ready = 1'b0;
      wait_ch(8'h00);
      iface_ready = 1'b1;
      repeat (190) @(negedge clk);
      chk(load_switch_channels, 8'h00);
      wait_ch(8'h81);
      $display("settle test done");
      end_sim();
   end
endmodule : test_isolated_octal_switch_serial_ctrl
`default_nettype wire
